//--- logic/cms_top.sv
// Purpose: Mode sequencer of a single-cell linear charger.
// Assumes: Analog comparators and the source detector deliver clean levels.
// Notes: Open-drain status pin: oe_n low means the pin is pulled low.
`include "cms_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - Pin low: programmed current; float: 100mA; high: 500mA.
// R2 - Detected source mode holds until the pin changes.
// R3 - Store pin level 532 us after power up.
// R4 - Detection ends 100 ms after pull-up, else 570 ms.
// R5 - Pin off stored level over 5 us releases detected mode.
// R6 - Host waits 600 ms after 3.4 V before driving pin.
// R7 - Temperature zones at 0, 10, 45, 60 degrees.
// R8 - 0 to 10 degrees halves current.
// R9 - 45 to 60 degrees lowers target to 4.1 V.
// R10 - Above 60 or below 0 degrees, no charge.
// R11 - Temp pin low disables; high enters bypass.
// R12 - Bypass entry resets timer, stops termination, detects.
// R13 - Bypass: no battery or taper releases status.
// R14 - Bypass exit detects and starts a new cycle.
// R15 - Pre-charge timer of 30 minutes.
// R16 - Fast timer 10 hours, half rate when limited.
// R17 - Timer expiry ends charge, releases status.
// R18 - Timers reset on disable, power cycle, bypass.
// R19 - Taper above recharge level releases status, detects, ends.
// R20 - Detect at bypass edges, when missing, at power-up (code: at power-up only above recharge level).
// R21 - No detect in bypass or temperature fault.
// R22 - Drop to recharge level restarts charge quietly.
// R23 - Termination threshold plus 14 percent in first minute.
// R24 - Status asserted only in first charge cycle.
// R25 - Pre-charge to fast above 2.5 V.
// R26 - Synchronise pin; count the 5 us check.
module cms_top #(
   parameter int AW = 8,
   parameter logic [63:0] CYC_SAMPLE = `CMS_CYC_SAMPLE,
   parameter logic [63:0] CYC_DET_PU = `CMS_CYC_DET_PU,
   parameter logic [63:0] CYC_DET_NOPU = `CMS_CYC_DET_NOPU,
   parameter logic [63:0] CYC_PRE = `CMS_CYC_PRE,
   parameter logic [63:0] CYC_FAST = `CMS_CYC_FAST,
   parameter logic [63:0] CYC_BOOST = `CMS_CYC_BOOST
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_power_ok,
   input wire logic input_limit_select_hi,
   input wire logic input_limit_select_lo,
   input wire logic src_usb_pullup,
   input wire logic src_dedicated,
   input wire cms_pkg::cms_temp_t temp,
   input wire cms_pkg::cms_sense_t sense,
   output cms_pkg::cms_lim_t input_limit_mode,
   output cms_pkg::cms_ctl_t ctl,
   output logic charge_status_out_o,
   output logic charge_status_out_oe_n,
   output logic power_good_out,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int TW = 42;
   localparam int SW = $clog2(CYC_SAMPLE + 64'h1);
   localparam int DW = $clog2(CYC_DET_NOPU + 64'h1);
   localparam int PW = 9;
   localparam logic [PW-1:0] PERSIST = PW'(`CMS_CYC_PERSIST);

   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [SW-1:0] smp_cnt;
      logic smp_done;
      cms_pkg::cms_lim_t stored;
      logic pu_seen;
      logic [DW-1:0] det_cnt;
      logic det_done;
      cms_pkg::cms_lim_t det_mode;
      logic released;
      logic [PW-1:0] per_cnt;
      cms_pkg::cms_lim_t lim;
      cms_pkg::cms_state_t state;
      logic chg_oe_n;
      logic pg;
      cms_pkg::cms_ctl_t ctl;
   } cms_top_st_t;

   cms_top_st_t st_ff;
   cms_top_st_t nxt_st;
   logic [31:0] ctrl_word;
   cms_pkg::cms_status_t status;
   cms_pkg::cms_lim_t pin_lvl;
   logic disabled;
   logic bypass;
   logic fault;
   logic charging;
   logic start;
   logic det_evt;
   logic clr_safety;
   logic pre_exp;
   logic fast_exp;
   logic boost_exp;

   // ************************************************************
   // Limit pin level and temperature classification
   // ************************************************************
   always_comb begin
      if (st_ff.sync2[1]) begin
         pin_lvl = cms_pkg::LIM_500; // see R1
      end else if (st_ff.sync2[0]) begin
         pin_lvl = cms_pkg::LIM_PROG; // see R1
      end else begin
         pin_lvl = cms_pkg::LIM_100; // see R1
      end
   end

   // A pulled-low temperature pin acts as a chip disable.
   assign disabled = !ctrl_word[`CMS_CTRL_EN_BIT] || temp.ts_low; // see R11
   assign bypass = temp.ts_high && !temp.ts_low; // see R11
   assign fault = temp.below0 || temp.above60; // see R7 see R10
   assign charging = (st_ff.state == cms_pkg::ST_PRE) ||
                     (st_ff.state == cms_pkg::ST_FAST) ||
                     (st_ff.state == cms_pkg::ST_BYP);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      nxt_st = st_ff;
      start = 1'h0;
      det_evt = 1'h0;
      // The first stage feeds only the second stage.
      nxt_st.sync1 = {input_limit_select_hi, input_limit_select_lo}; // see R26
      nxt_st.sync2 = st_ff.sync1; // see R26
      nxt_st.pg = in_power_ok;

      if (!st_ff.smp_done) begin
         if (st_ff.smp_cnt == SW'(CYC_SAMPLE)) begin
            nxt_st.smp_done = 1'h1; // see R3
            nxt_st.stored = pin_lvl; // see R3
         end else begin
            nxt_st.smp_cnt = st_ff.smp_cnt + 1'b1;
         end
      end

      // The detection window restarts when a data-line pull-up first shows.
      if (!st_ff.det_done) begin
         nxt_st.det_cnt = st_ff.det_cnt + 1'b1;
         if (src_usb_pullup && !st_ff.pu_seen) begin
            nxt_st.pu_seen = 1'h1;
            nxt_st.det_cnt = '0;
         end else if (st_ff.pu_seen ? (st_ff.det_cnt == DW'(CYC_DET_PU)) :
                      (st_ff.det_cnt == DW'(CYC_DET_NOPU))) begin // see R4
            nxt_st.det_done = 1'h1;
            nxt_st.det_mode = src_dedicated ? cms_pkg::LIM_PROG :
                              cms_pkg::LIM_100; // see R2
         end
      end

      if (st_ff.det_done && st_ff.smp_done && !st_ff.released) begin
         if (pin_lvl != st_ff.stored) begin
            if (st_ff.per_cnt == PERSIST) begin
               nxt_st.released = 1'h1; // see R5
            end else begin
               nxt_st.per_cnt = st_ff.per_cnt + 1'b1; // see R26
            end
         end else begin
            nxt_st.per_cnt = '0; // see R26
         end
      end

      if (st_ff.released) begin
         nxt_st.lim = pin_lvl; // see R1 see R5
      end else if (st_ff.det_done) begin
         nxt_st.lim = st_ff.det_mode; // see R2
      end else begin
         nxt_st.lim = cms_pkg::LIM_100;
      end

      // ---- Charge sequencing ----
      if (disabled) begin
         nxt_st.state = cms_pkg::ST_OFF; // see R11
         nxt_st.chg_oe_n = 1'h1;
      end else if (bypass) begin
         if (st_ff.state != cms_pkg::ST_BYP) begin
            nxt_st.state = cms_pkg::ST_BYP; // see R12
            det_evt = 1'h1; // see R12 see R20
         end
         if (!sense.batt_present || sense.taper) begin
            nxt_st.chg_oe_n = 1'h1; // see R13
         end
      end else begin
         unique case (st_ff.state)
            cms_pkg::ST_OFF: begin
               // Enabling or powering up starts a first charge.
               nxt_st.state = cms_pkg::ST_PRE;
               nxt_st.chg_oe_n = 1'h0; // see R24
               start = 1'h1;
               det_evt = sense.above_rch; // see R20
            end
            cms_pkg::ST_BYP: begin
               nxt_st.state = cms_pkg::ST_PRE; // see R14
               start = 1'h1; // see R14
               det_evt = 1'h1; // see R14 see R20
            end
            cms_pkg::ST_PRE: begin
               if (pre_exp) begin
                  nxt_st.state = cms_pkg::ST_TOUT; // see R17
                  nxt_st.chg_oe_n = 1'h1; // see R17
               end else if (sense.above_lowv) begin
                  nxt_st.state = cms_pkg::ST_FAST; // see R25
               end
            end
            cms_pkg::ST_FAST: begin
               if (fast_exp) begin
                  nxt_st.state = cms_pkg::ST_TOUT; // see R17
                  nxt_st.chg_oe_n = 1'h1; // see R17
               end else if (sense.above_rch && sense.taper) begin
                  nxt_st.chg_oe_n = 1'h1; // see R19
                  det_evt = 1'h1; // see R19
                  if (sense.batt_present) begin
                     nxt_st.state = cms_pkg::ST_DONE; // see R19
                  end
               end
            end
            cms_pkg::ST_DONE: begin
               if (sense.below_rch) begin
                  // The status pin is left as it is on a refresh.
                  nxt_st.state = cms_pkg::ST_PRE; // see R22 see R24
                  start = 1'h1; // see R22
               end
            end
            cms_pkg::ST_TOUT: begin
               nxt_st.state = cms_pkg::ST_TOUT; // see R17
            end
            default: begin
               nxt_st.state = cms_pkg::ST_OFF;
            end
         endcase
         if (!sense.batt_present) begin
            nxt_st.chg_oe_n = 1'h1; // see R20
         end
      end

      // ---- Outputs toward the analog loops ----
      nxt_st.ctl.charge_en = charging && !disabled && !fault; // see R10
      nxt_st.ctl.half_current = temp.below10 && !temp.below0; // see R8
      nxt_st.ctl.vreg_reduced = temp.above45 && !temp.above60; // see R9
      nxt_st.ctl.term_en = !bypass; // see R12
      nxt_st.ctl.term_boost = charging && !boost_exp; // see R23
      nxt_st.ctl.precharge = charging && !sense.above_lowv; // see R25
      nxt_st.ctl.bat_detect_run = !fault && !disabled &&
         (det_evt || (!sense.batt_present && !bypass)); // see R20 see R21

      // A power cycle restarts detection and the whole sequence.
      if (!in_power_ok) begin
         nxt_st = '0; // see R18
         nxt_st.chg_oe_n = 1'h1;
         start = 1'h0;
         det_evt = 1'h0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.chg_oe_n <= 1'h1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // Safety and first-minute timers
   // ************************************************************
   assign clr_safety = !in_power_ok || disabled || bypass || start; // see R12 see R18

   cms_timer #(
      .W(TW),
      .LIMIT(CYC_PRE[TW-1:0])
   ) u_pre_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(clr_safety),
      .run((st_ff.state == cms_pkg::ST_PRE) && !fault), // see R15
      .half(1'h0),
      .expired(pre_exp)
   );

   cms_timer #(
      .W(TW),
      .LIMIT(CYC_FAST[TW-1:0])
   ) u_fast_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(clr_safety),
      .run((st_ff.state == cms_pkg::ST_FAST) && !fault), // see R16
      .half(sense.thermal_reg || sense.fold_reg || sense.usb_limit), // see R16
      .expired(fast_exp)
   );

   cms_timer #(
      .W(TW),
      .LIMIT(CYC_BOOST[TW-1:0])
   ) u_boost_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .clear(start || !in_power_ok || disabled), // see R23
      .run(charging),
      .half(1'h0),
      .expired(boost_exp)
   );

   // ************************************************************
   // Register bus
   // ************************************************************
   always_comb begin
      status = '0;
      status.pg = st_ff.pg;
      status.fast_exp = fast_exp;
      status.pre_exp = pre_exp;
      status.chg_on = !st_ff.chg_oe_n;
      status.released = st_ff.released;
      status.det_done = st_ff.det_done;
      status.lim = st_ff.lim;
      status.state = st_ff.state;
   end

   cms_axil #(
      .AW(AW)
   ) u_axil (
      .mclk(mclk),
      .rst_n(rst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .status_word(status),
      .ctrl_word(ctrl_word)
   );

   // ************************************************************
   // Pin outputs
   // ************************************************************
   assign input_limit_mode = st_ff.lim;
   assign ctl = st_ff.ctl;
   assign charge_status_out_o = 1'h0;
   assign charge_status_out_oe_n = st_ff.chg_oe_n; // see R24
   assign power_good_out = st_ff.pg;
endmodule // cms_top
`default_nettype wire

//--- inc/cms_cfg.svh
// Purpose: Timing, register and reset constants of the charger sequencer.
// Assumes: mclk runs at 50 MHz.
// Notes: Cycle counts are derived from the times in their own units.
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH
`define CMS_CLK_NS 64'h14
`define CMS_T_SAMPLE_NS 64'd532000
`define CMS_T_DET_PU_MS 64'd100
`define CMS_T_DET_NOPU_MS 64'd570
`define CMS_T_PERSIST_NS 64'd5000
`define CMS_T_PRE_MIN 64'd30
`define CMS_T_FAST_H 64'd10
`define CMS_T_BOOST_MIN 64'd1
`define CMS_NS_PER_MS 64'd1000000
`define CMS_NS_PER_MIN 64'd60000000000
`define CMS_CYC_SAMPLE ((`CMS_T_SAMPLE_NS + `CMS_CLK_NS - 64'h1) / `CMS_CLK_NS)
`define CMS_CYC_DET_PU (`CMS_T_DET_PU_MS * `CMS_NS_PER_MS / `CMS_CLK_NS)
`define CMS_CYC_DET_NOPU (`CMS_T_DET_NOPU_MS * `CMS_NS_PER_MS / `CMS_CLK_NS)
`define CMS_CYC_PERSIST ((`CMS_T_PERSIST_NS + `CMS_CLK_NS - 64'h1) / `CMS_CLK_NS)
`define CMS_CYC_PRE (`CMS_T_PRE_MIN * `CMS_NS_PER_MIN / `CMS_CLK_NS)
`define CMS_CYC_FAST (`CMS_T_FAST_H * 64'd60 * `CMS_NS_PER_MIN / `CMS_CLK_NS)
`define CMS_CYC_BOOST (`CMS_T_BOOST_MIN * `CMS_NS_PER_MIN / `CMS_CLK_NS)
`define CMS_OFS_CTRL 8'h00
`define CMS_OFS_STATUS 8'h04
`define CMS_CTRL_RST 32'h0000_0001
`define CMS_CTRL_MASK 32'h0000_0001
`define CMS_CTRL_EN_BIT 0
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_DECERR 2'h3
`endif

//--- inc/cms_pkg.sv
// Purpose: Types shared by the charger sequencer files.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Constants live in cms_cfg.svh.
package cms_pkg;
   typedef enum logic [1:0] {
      LIM_PROG = 2'h0,
      LIM_100 = 2'h1,
      LIM_500 = 2'h2
   } cms_lim_t;
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_PRE = 3'h1,
      ST_FAST = 3'h3,
      ST_DONE = 3'h2,
      ST_BYP = 3'h6,
      ST_TOUT = 3'h4
   } cms_state_t;
   typedef struct packed {
      logic ts_low;
      logic ts_high;
      logic below0;
      logic below10;
      logic above45;
      logic above60;
   } cms_temp_t;
   typedef struct packed {
      logic above_rch;
      logic below_rch;
      logic above_lowv;
      logic taper;
      logic batt_present;
      logic thermal_reg;
      logic fold_reg;
      logic usb_limit;
   } cms_sense_t;
   typedef struct packed {
      logic charge_en;
      logic half_current;
      logic vreg_reduced;
      logic term_en;
      logic term_boost;
      logic precharge;
      logic bat_detect_run;
   } cms_ctl_t;
   typedef struct packed {
      logic [20:0] rsvd;
      logic pg;
      logic fast_exp;
      logic pre_exp;
      logic chg_on;
      logic released;
      logic det_done;
      cms_lim_t lim;
      cms_state_t state;
   } cms_status_t;
endpackage

//--- logic/cms_timer.sv
// Purpose: Safety timer with optional half-rate counting.
// Assumes: clear has priority over run.
// Notes: expired stays high until clear.
`timescale 1ns/1ps
`default_nettype none
module cms_timer #(
   parameter int W = 41,
   parameter logic [W-1:0] LIMIT = '1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   input wire logic half,
   output logic expired
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic phase;
      logic done;
   } cms_tmr_st_t;
   cms_tmr_st_t st_ff;
   cms_tmr_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (clear) begin
         nxt_st = '0;
      end else if (run && !st_ff.done) begin
         nxt_st.phase = ~st_ff.phase;
         if (!half || st_ff.phase) begin
            if (st_ff.cnt == LIMIT - 1'b1) begin
               nxt_st.done = 1'h1;
            end else begin
               nxt_st.cnt = st_ff.cnt + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign expired = st_ff.done;
endmodule // cms_timer
`default_nettype wire

//--- logic/cms_axil.sv
// Purpose: AXI4-Lite slave holding the control word and reading status.
// Assumes: One write and one read outstanding at most.
// Notes: Unmapped addresses answer DECERR, reads return zero.
`include "cms_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cms_axil #(
   parameter int AW = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] status_word,
   output logic [31:0] ctrl_word
);
   typedef struct packed {
      logic aw_held;
      logic [AW-1:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] ctrl;
   } cms_axi_st_t;
   cms_axi_st_t st_ff;
   cms_axi_st_t nxt_st;

   function automatic logic is_at(input logic [AW-1:0] a, input logic [7:0] ofs);
      is_at = ({a[AW-1:2], 2'h0} == AW'(ofs));
   endfunction

   always_comb begin
      nxt_st = st_ff;
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_held = 1'h1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_held = 1'h1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'h0;
      end
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
         nxt_st.aw_held = 1'h0;
         nxt_st.w_held = 1'h0;
         nxt_st.bvalid = 1'h1;
         nxt_st.bresp = `CMS_RESP_OKAY;
         if (is_at(st_ff.awaddr, `CMS_OFS_CTRL)) begin
            for (int i = 0; i < 4; i++) begin
               if (st_ff.wstrb[i]) begin
                  nxt_st.ctrl[i*8 +: 8] = st_ff.wdata[i*8 +: 8];
               end
            end
            nxt_st.ctrl = nxt_st.ctrl & `CMS_CTRL_MASK;
         end else if (!is_at(st_ff.awaddr, `CMS_OFS_STATUS)) begin
            nxt_st.bresp = `CMS_RESP_DECERR;
         end
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'h0;
      end
      if (s_axi_arvalid && st_ff.arready) begin
         nxt_st.rvalid = 1'h1;
         nxt_st.rresp = `CMS_RESP_OKAY;
         nxt_st.rdata = 32'h0;
         if (is_at(s_axi_araddr, `CMS_OFS_CTRL)) begin
            nxt_st.rdata = st_ff.ctrl;
         end else if (is_at(s_axi_araddr, `CMS_OFS_STATUS)) begin
            nxt_st.rdata = status_word;
         end else begin
            nxt_st.rresp = `CMS_RESP_DECERR;
         end
      end
      nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
      nxt_st.arready = !nxt_st.rvalid;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.ctrl <= `CMS_CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign ctrl_word = st_ff.ctrl;
endmodule // cms_axil
`default_nettype wire

//--- testbench/cms_pack.sv
// Purpose: Battery pack, thermistor and sense model facing the sequencer.
// Assumes: The bench sets temperature, sense pin mode and pack state.
// Notes: A floated sense pin reads as neither low nor high.
`timescale 1ns/1ps
`default_nettype none
module cms_pack (
   input wire logic signed [7:0] deg,
   input wire logic [1:0] tsm,
   input wire cms_pkg::cms_sense_t bat,
   output cms_pkg::cms_temp_t temp,
   output cms_pkg::cms_sense_t sense
);
   assign temp = {tsm == 2'h1, tsm == 2'h2, deg < 8'sh00, deg < 8'sh0a, deg > 8'sh2d,
                  deg > 8'sh3c};
   assign sense = bat;
endmodule // cms_pack
`default_nettype wire

//--- testbench/cms_top_properties.sv
// Purpose: Concurrent checks on the sequencer ports.
// Assumes: Outputs follow inputs by one cycle.
// Notes: Bound into cms_top.
`timescale 1ns/1ps
`default_nettype none
module cms_top_properties (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_power_ok,
   input wire cms_pkg::cms_temp_t temp,
   input wire cms_pkg::cms_sense_t sense,
   input wire cms_pkg::cms_ctl_t ctl,
   input wire logic charge_status_out_oe_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   sequence s_byp;
      temp.ts_high [*2];
   endsequence
   sequence s_nobat;
      (temp.ts_high && !sense.batt_present) [*2];
   endsequence
   AST_COLD:
   assert property (temp.below10 && !temp.below0 && ctl.charge_en |=> ctl.half_current)
      else $error("cold current not halved");
   AST_WARM:
   assert property (temp.above45 && !temp.above60 && ctl.charge_en |=> ctl.vreg_reduced)
      else $error("warm target not lowered");
   AST_FAULT:
   assert property (temp.above60 || temp.below0 |=> !ctl.charge_en) else $error("fault charge");
   AST_LOW:
   assert property (temp.ts_low |=> !ctl.charge_en) else $error("low pin charge");
   AST_BYP:
   assert property (s_byp |=> !ctl.term_en) else $error("bypass termination on");
   AST_NOBAT:
   assert property (s_nobat |-> ##[1:3] charge_status_out_oe_n) else $error("status held");
   AST_TAPER:
   assert property (ctl.charge_en && ctl.term_en && !ctl.precharge && sense.taper &&
      sense.above_rch |-> ##[1:3] charge_status_out_oe_n) else $error("taper status held");
   AST_PWR:
   assert property (!in_power_ok |=> !ctl.charge_en && charge_status_out_oe_n)
      else $error("power loss ignored");
endmodule // cms_top_properties
bind cms_top cms_top_properties cms_top_properties_inst (.mclk, .rst_n, .in_power_ok, .temp,
   .sense, .ctl, .charge_status_out_oe_n);
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench of the charger sequencer.
// Assumes: Shortened timer parameters.
// Notes: Register reads are scored from a queue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin fail_count++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
   logic mclk = 0, rst_n = 0, pwr = 1, hi = 0, lo = 1, av = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wrd, bv, arr, rv, oe_n;
   logic pu = 1, ded = 1, pg, cso;
   logic [1:0] rresp, bresp;
   logic [3:0] ws = 4'hf;
   logic [7:0] wa = 0;
   logic [1:0] pins[3] = '{2'h2, 2'h0, 2'h1};
   logic [7:0] ra = 0;
   logic [31:0] wd = 0, rdata;
   logic [65:0] q[$], n;
   logic signed [7:0] deg = 8'h19;
   logic signed [7:0] tdeg[5] = '{8'hfb, 8'h05, 8'h19, 8'h32, 8'h46};
   logic [1:0] tsm = 0;
   cms_pkg::cms_sense_t sn = 8'h08;
   cms_pkg::cms_temp_t temp;
   cms_pkg::cms_sense_t sense;
   cms_pkg::cms_ctl_t ctl;
   cms_pkg::cms_lim_t lim;
   cms_pkg::cms_lim_t lims[3] = '{cms_pkg::LIM_500, cms_pkg::LIM_100, cms_pkg::LIM_PROG};
   int fail_count = 0, compares = 0, cyc = 0, i;
   always #10 mclk = ~mclk;
   cms_pack cms_pack_inst (.deg, .tsm, .bat(sn), .temp, .sense);
   cms_top #(.CYC_SAMPLE(64'h14), .CYC_DET_PU(64'h1e), .CYC_DET_NOPU(64'h3c),
      .CYC_PRE(64'h64), .CYC_FAST(64'hc8), .CYC_BOOST(64'h32)) cms_top_inst (.mclk, .rst_n,
      .in_power_ok(pwr), .input_limit_select_hi(hi), .input_limit_select_lo(lo),
      .src_usb_pullup(pu), .src_dedicated(ded), .temp, .sense, .input_limit_mode(lim),
      .ctl, .charge_status_out_o(cso), .charge_status_out_oe_n(oe_n), .power_good_out(pg),
      .s_axi_awaddr(wa), .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr));
   task automatic wr(input logic [31:0] d);
      logic pa = 1;
      logic pw = 1;
      @(posedge mclk);
      wd <= d;
      av <= 1;
      wv <= 1;
      br <= 1;
      while (pa || pw) begin
         @(posedge mclk);
         pa = pa && !awr;
         pw = pw && !wrd;
         av <= pa;
         wv <= pw;
      end
      do @(posedge mclk); while (!bv);
      `CHK("bresp", 2'h0, bresp)
      br <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
      @(posedge mclk);
      q.push_back({m, e});
      ra <= a;
      arv <= 1;
      rr <= 1;
      do @(posedge mclk); while (!arr);
      arv <= 0;
      do @(posedge mclk); while (!rv);
      rr <= 0;
   endtask
   task automatic finish_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         fail_count++;
         finish_test();
      end
      if (rv && rr) begin
         n = q.pop_front();
         `CHK("read", n[33:0], {rresp, rdata & n[65:34]})
      end
   end
   initial begin
      i = $urandom(32'h41c3);
      tdeg[2] = 8'h0b + 8'($urandom % 32'h22);
      repeat (20) @(posedge mclk);
      rst_n <= 1;
      repeat (50) @(posedge mclk);
      rd(8'h04, 32'h3f, 34'h21);
      `CHK("status pin", 1'b0, oe_n)
      `CHK("status drive", 1'b0, cso)
      for (i = 0; i < 3; i++) begin
         {hi, lo} <= pins[i];
         repeat (260) @(posedge mclk);
         `CHK("limit", lims[i], lim)
      end
      rd(8'h04, 32'h1c7, 34'h144);
      wr(32'h0);
      sn <= 8'h2c;
      wr($urandom | 32'h1);
      rd(8'h00, '1, 34'h1);
      rd(8'h08, '1, {2'h3, 32'h0});
      repeat (300) @(posedge mclk);
      rd(8'h04, 32'h207, 34'h3);
      repeat (150) @(posedge mclk);
      rd(8'h04, 32'h207, 34'h204);
      $display("test limit and timers done");
      wr(32'h0);
      sn <= 8'h28;
      wr(32'h1);
      repeat (5) @(posedge mclk);
      sn <= 8'hb8;
      repeat (5) @(posedge mclk);
      rd(8'h04, 32'h87, 34'h2);
      sn <= 8'h48;
      repeat (5) @(posedge mclk);
      rd(8'h04, 32'h87, 34'h1);
      tsm <= 2'h2;
      sn <= 8'h00;
      repeat (5) @(posedge mclk);
      rd(8'h04, 32'h87, 34'h6);
      tsm <= 2'h0;
      sn <= 8'h08;
      repeat (5) @(posedge mclk);
      rd(8'h04, 32'h87, 34'h1);
      $display("test charge cycle done");
      for (i = 0; i < 5; i++) begin
         deg <= tdeg[i];
         repeat (4) @(posedge mclk);
      end
      `CHK("hot charge", 1'b0, ctl.charge_en)
      deg <= 8'h19;
      tsm <= 2'h1;
      repeat (4) @(posedge mclk);
      `CHK("low charge", 1'b0, ctl.charge_en)
      tsm <= 2'h0;
      pwr <= 0;
      repeat (3) @(posedge mclk);
      pwr <= 1;
      repeat (5) @(posedge mclk);
      `CHK("status pin", 1'b0, oe_n)
      `CHK("power good", 1'b1, pg)
      $display("test temperature and power done");
      finish_test();
   end
endmodule // tb
`default_nettype wire
